// ==== rtl/perr_pkg.sv ====
// constants shared by the error report register bank
package perr_pkg;
    // special addresses of the bank
    localparam logic [31:0] addr_forcing_map   = 32'hf000001f;
    localparam logic [31:0] addr_prev_status   = 32'hf0000020;
    localparam logic [31:0] addr_err_summary   = 32'hf0000021;
    localparam logic [31:0] addr_ctrl_mask     = 32'hf0000022;
    localparam logic [31:0] addr_force_mask    = 32'hf0000023;
    localparam logic [31:0] addr_self_test     = 32'hf0000024;
    localparam logic [31:0] addr_group_first   = 32'hf000001b;
    localparam logic [31:0] addr_group_last    = 32'hf0000021;
    // reset values
    localparam logic [15:0] rst_summary        = 16'h00ff;
    localparam logic [15:0] rst_mask           = 16'hffff;
    localparam logic [15:0] rst_zero           = 16'h0000;
    // field positions
    localparam int          bit_wait           = 2;
    localparam int          bit_bus_request    = 0;
    localparam int          bit_multi_micro    = 10;
    localparam int          bit_timeout        = 11;
    // default address ranges
    localparam logic [31:0] learn_lo_a         = 32'h0d000000;
    localparam logic [31:0] learn_hi_a         = 32'h0d00fffe;
    localparam logic [31:0] learn_lo_b         = 32'h08000000;
    localparam logic [31:0] learn_hi_b         = 32'h0800fffe;
    localparam logic [31:0] bus_test_addr      = 32'h0800fffe;
    // wait timeout in fast mode
    localparam int          wait_limit         = 128;
    localparam logic [7:0]  wait_limit_count   = 8'h80;
    typedef enum logic [1:0] {perr_idle, perr_access, perr_done} perr_state_t;
endpackage

// ==== rtl/perr_sync.sv ====
// three-stage input synchroniser with agreement filter
module perr_sync (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic s1;
    logic s2;
    logic s3;
    // first stage feeds only the second
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q_out <= 1'b0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_out <= s3;
            end
        end
    end
endmodule

// ==== rtl/perr_wait_timer.sv ====
// counts wait cycles during an access and flags the fast-mode timeout
module perr_wait_timer (
    input  wire logic clock_in,
    input  wire logic rstn_in,
    input  wire logic active_in,
    input  wire logic wait_in,
    output logic      expired_out
);
    logic [7:0] count;
    wire        at_limit = (count == perr_pkg::wait_limit_count - 8'h01);
    // restart each access; counts only while wait is held
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= 8'h00;
            expired_out <= 1'b0;
        end else if (!active_in || !wait_in) begin
            count <= 8'h00;
            expired_out <= 1'b0;
        end else if (at_limit) begin
            expired_out <= 1'b1;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule

// ==== rtl/perr_regs.sv ====
// error report register bank of the test pod
module perr_regs (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // special-address command port from the mainframe
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [31:0] cmd_addr_in,
    input  wire logic [15:0] cmd_wdata_in,
    output logic             cmd_ack_out,
    output logic             cmd_hit_out,
    output logic [15:0]      cmd_rdata_out,
    output logic             dummy_read_req_out,
    // setup controls
    input  wire logic        fast_mode_in,
    input  wire logic        wait_enable_in,
    input  wire logic        bus_request_enable_in,
    input  wire logic        bus_test_addr_set_in,
    input  wire logic [31:0] bus_test_addr_in,
    // target access handshake
    input  wire logic        access_start_in,
    input  wire logic        access_end_in,
    input  wire logic        wait_line_in,
    input  wire logic        bus_request_line_in,
    input  wire logic [15:0] live_status_in,
    input  wire logic [15:0] control_drive_err_in,
    input  wire logic [7:0]  fault_byte_in,
    // outputs toward the target side and reporting
    output logic             access_abort_out,
    output logic [15:0]      reported_ctrl_err_out,
    output logic [15:0]      reported_force_err_out,
    output logic [31:0]      bus_test_data_addr_out,
    output logic [31:0]      learn_lo_a_out,
    output logic [31:0]      learn_hi_a_out,
    output logic [31:0]      learn_lo_b_out,
    output logic [31:0]      learn_hi_b_out
);
    perr_pkg::perr_state_t state;
    perr_pkg::perr_state_t next_state;

    logic [15:0] forcing_line_error_map;
    logic [15:0] previous_status_word;
    logic [15:0] error_summary_byte;
    logic [15:0] control_drive_report_mask;
    logic [15:0] forcing_line_report_mask;
    logic [15:0] self_test_diagnostic;
    logic [15:0] ctrl_err_capture;
    logic [15:0] force_accum;
    logic        timeout_seen;
    logic        wait_sync;
    logic        bus_request_line_sync;
    logic        wait_expired;

    function automatic logic is_group(input logic [31:0] a);
        is_group = (a >= perr_pkg::addr_group_first) && (a <= perr_pkg::addr_group_last);
    endfunction

    // pins from the target side cross into our clock
    perr_sync u_sync_wait (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .d_in     (wait_line_in),
        .q_out    (wait_sync)
    );
    perr_sync u_sync_bus_request_line (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .d_in     (bus_request_line_in),
        .q_out    (bus_request_line_sync)
    );

    wire in_access = (state == perr_pkg::perr_access);
    // fast mode arms the wait watchdog; outside it wait just stretches
    perr_wait_timer u_wait_timer (
        .clock_in    (clock_in),
        .rstn_in     (rstn_in),
        .active_in   (in_access && fast_mode_in),
        .wait_in     (wait_sync),
        .expired_out (wait_expired)
    );

    // forcing lines asserted while disabled; only wait and bus request are gated by setup
    wire [15:0] force_now;
    assign force_now = {13'h0000,
                        wait_sync && !wait_enable_in,
                        1'b0,
                        bus_request_line_sync && !bus_request_enable_in};

    wire access_finish = in_access && (access_end_in || wait_expired);
    wire [15:0] status_final = timeout_seen || wait_expired
                             ? (live_status_in | (16'h0001 << perr_pkg::bit_timeout))
                             : live_status_in;

    // access sequencing
    always_comb begin
        next_state = state;
        case (state)
            perr_pkg::perr_idle: begin
                if (access_start_in) begin
                    next_state = perr_pkg::perr_access;
                end
            end
            perr_pkg::perr_access: begin
                if (access_finish) begin
                    next_state = perr_pkg::perr_done;
                end
            end
            perr_pkg::perr_done: begin
                next_state = perr_pkg::perr_idle;
            end
            default: begin
                next_state = perr_pkg::perr_idle;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= perr_pkg::perr_idle;
        end else begin
            state <= next_state;
        end
    end

    // accumulate forcing errors and timeout over one access
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            force_accum <= perr_pkg::rst_zero;
            timeout_seen <= 1'b0;
        end else if (state == perr_pkg::perr_idle) begin
            force_accum <= perr_pkg::rst_zero;
            timeout_seen <= 1'b0;
        end else if (in_access) begin
            force_accum <= force_accum | force_now;
            timeout_seen <= timeout_seen | wait_expired;
        end
    end

    // captures replaced at the end of each access, masks play no part here
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            forcing_line_error_map <= perr_pkg::rst_zero;
            previous_status_word <= perr_pkg::rst_zero;
            error_summary_byte <= perr_pkg::rst_summary;
            ctrl_err_capture <= perr_pkg::rst_zero;
        end else if (access_finish) begin
            forcing_line_error_map <= force_accum | force_now;
            previous_status_word <= status_final;
            error_summary_byte <= {8'h00, fault_byte_in};
            ctrl_err_capture <= control_drive_err_in;
        end
    end

    // writes from the mainframe
    wire wr = cmd_valid_in && cmd_write_in;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            control_drive_report_mask <= perr_pkg::rst_mask;
            forcing_line_report_mask <= perr_pkg::rst_mask;
            self_test_diagnostic <= perr_pkg::rst_zero;
        end else if (wr) begin
            if (cmd_addr_in == perr_pkg::addr_ctrl_mask) begin
                control_drive_report_mask <= cmd_wdata_in;
            end
            if (cmd_addr_in == perr_pkg::addr_force_mask) begin
                forcing_line_report_mask <= cmd_wdata_in;
            end
            if (cmd_addr_in == perr_pkg::addr_self_test) begin
                self_test_diagnostic <= cmd_wdata_in;
            end
        end
    end

    // read decode; group reads serve stored values only
    wire        hit_force = (cmd_addr_in == perr_pkg::addr_forcing_map);
    wire        hit_stat  = (cmd_addr_in == perr_pkg::addr_prev_status);
    wire        hit_sum   = (cmd_addr_in == perr_pkg::addr_err_summary);
    wire        hit_cmask = (cmd_addr_in == perr_pkg::addr_ctrl_mask);
    wire        hit_fmask = (cmd_addr_in == perr_pkg::addr_force_mask);
    wire        hit_self  = (cmd_addr_in == perr_pkg::addr_self_test);
    wire        hit_any   = hit_force | hit_stat | hit_sum | hit_cmask | hit_fmask | hit_self;
    wire [15:0] rd_mux    = hit_force ? forcing_line_error_map :
                            hit_stat  ? previous_status_word :
                            hit_sum   ? error_summary_byte :
                            hit_cmask ? control_drive_report_mask :
                            hit_fmask ? forcing_line_report_mask :
                            hit_self  ? self_test_diagnostic : 16'h0000;
    // forcing-line report includes timeout at its status position
    wire [15:0] force_report = forcing_line_error_map
                             | (previous_status_word & (16'h0001 << perr_pkg::bit_timeout));
    wire rd_other = cmd_valid_in && !cmd_write_in && !is_group(cmd_addr_in);

    // registered answers and outputs
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_ack_out <= 1'b0;
            cmd_hit_out <= 1'b0;
            cmd_rdata_out <= perr_pkg::rst_zero;
            dummy_read_req_out <= 1'b0;
            access_abort_out <= 1'b0;
            reported_ctrl_err_out <= perr_pkg::rst_zero;
            reported_force_err_out <= perr_pkg::rst_zero;
            bus_test_data_addr_out <= perr_pkg::bus_test_addr;
        end else begin
            cmd_ack_out <= cmd_valid_in;
            cmd_hit_out <= cmd_valid_in && hit_any;
            cmd_rdata_out <= (cmd_valid_in && !cmd_write_in) ? rd_mux : 16'h0000;
            dummy_read_req_out <= rd_other;
            access_abort_out <= in_access && wait_expired;
            reported_ctrl_err_out <= ctrl_err_capture & control_drive_report_mask;
            reported_force_err_out <= force_report & forcing_line_report_mask;
            if (bus_test_addr_set_in) begin
                bus_test_data_addr_out <= bus_test_addr_in;
            end
        end
    end

    // learn default ranges are fixed
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            learn_lo_a_out <= perr_pkg::learn_lo_a;
            learn_hi_a_out <= perr_pkg::learn_hi_a;
            learn_lo_b_out <= perr_pkg::learn_lo_b;
            learn_hi_b_out <= perr_pkg::learn_hi_b;
        end else begin
            learn_lo_a_out <= perr_pkg::learn_lo_a;
            learn_hi_a_out <= perr_pkg::learn_hi_a;
            learn_lo_b_out <= perr_pkg::learn_lo_b;
            learn_hi_b_out <= perr_pkg::learn_hi_b;
        end
    end
endmodule

// ==== dv/perr_regs_sva.sv ====
// assertion checker for the error report register bank
module perr_regs_chk (
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic        cmd_valid_in,
    input wire logic        cmd_write_in,
    input wire logic [31:0] cmd_addr_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic        cmd_ack_out,
    input wire logic [15:0] cmd_rdata_out,
    input wire logic        dummy_read_req_out,
    input wire logic        fast_mode_in,
    input wire logic        bus_test_addr_set_in,
    input wire logic [31:0] bus_test_addr_in,
    input wire logic        access_abort_out,
    input wire logic [15:0] reported_ctrl_err_out,
    input wire logic [15:0] reported_force_err_out,
    input wire logic [31:0] bus_test_data_addr_out,
    input wire logic [31:0] learn_lo_a_out,
    input wire logic [31:0] learn_hi_b_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);
    // command decode shared by the properties
    wire rd_cmd = cmd_valid_in && !cmd_write_in;
    wire wr_cmd = cmd_valid_in && cmd_write_in;
    wire in_grp = cmd_addr_in >= perr_pkg::addr_group_first
                  && cmd_addr_in <= perr_pkg::addr_group_last;
    a_ack_one_cycle: assert property (cmd_valid_in |=> cmd_ack_out) else $error("no ack");
    a_group_no_dummy: assert property (rd_cmd && in_grp |=> !dummy_read_req_out)
        else $error("dummy read on group read");
    a_other_dummy: assert property (rd_cmd && !in_grp |=> dummy_read_req_out)
        else $error("no dummy read outside group");
    a_summary_upper_zero: assert property (rd_cmd && cmd_addr_in == perr_pkg::addr_err_summary
        |=> cmd_rdata_out[15:8] == 8'h00) else $error("summary upper byte set");
    // masks take effect one cycle after the register update
    a_ctrl_mask_gates: assert property (wr_cmd && cmd_addr_in == perr_pkg::addr_ctrl_mask |=> ##1
        (reported_ctrl_err_out & ~$past(cmd_wdata_in, 2)) == 16'h0000)
        else $error("ctrl report ignores mask");
    a_force_mask_gates: assert property (wr_cmd && cmd_addr_in == perr_pkg::addr_force_mask |=> ##1
        (reported_force_err_out & ~$past(cmd_wdata_in, 2)) == 16'h0000)
        else $error("force report ignores mask");
    // only wait, bus request and timeout can ever be reported as forcing errors
    a_force_bits_only: assert property ((reported_force_err_out & 16'hf7fa) == 16'h0000)
        else $error("unexpected forcing bit");
    a_abort_pulse: assert property (access_abort_out |=> !access_abort_out)
        else $error("abort longer than one cycle");
    a_abort_fast_only: assert property (access_abort_out |-> $past(fast_mode_in))
        else $error("abort outside fast mode");
    a_bus_test_load: assert property (bus_test_addr_set_in
        |=> bus_test_data_addr_out == $past(bus_test_addr_in)) else $error("bus test addr");
    a_learn_ranges: assert property (learn_lo_a_out == perr_pkg::learn_lo_a
        && learn_hi_b_out == perr_pkg::learn_hi_b) else $error("learn range wrong");
    c_abort: cover property (access_abort_out);
    c_dummy: cover property (dummy_read_req_out);
    c_mask_write: cover property (wr_cmd && cmd_addr_in == perr_pkg::addr_ctrl_mask);
endmodule

bind perr_regs perr_regs_chk u_chk (.clock_in, .rstn_in, .cmd_valid_in, .cmd_write_in,
    .cmd_addr_in, .cmd_wdata_in, .cmd_ack_out, .cmd_rdata_out, .dummy_read_req_out,
    .fast_mode_in, .bus_test_addr_set_in, .bus_test_addr_in, .access_abort_out,
    .reported_ctrl_err_out, .reported_force_err_out, .bus_test_data_addr_out,
    .learn_lo_a_out, .learn_hi_b_out);

// ==== dv/perr_mainframe.sv ====
// mainframe model issuing special-address commands
module perr_mainframe (
    input  wire logic        clock_in,
    input  wire logic        cmd_ack_in,
    input  wire logic        cmd_hit_in,
    input  wire logic [15:0] cmd_rdata_in,
    input  wire logic        dummy_in,
    output logic             cmd_valid_out,
    output logic             cmd_write_out,
    output logic [31:0]      cmd_addr_out,
    output logic [15:0]      cmd_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_addr_out = 32'h00000000;
        cmd_wdata_out = 16'h0000;
    end
    // one-cycle request, then address and data scrambled so stale values never match
    task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic h, output logic dm);
        int n;
        @(posedge clock_in);
        cmd_valid_out <= 1'b1;
        cmd_write_out <= w;
        cmd_addr_out <= a;
        cmd_wdata_out <= d;
        @(posedge clock_in);
        cmd_valid_out <= 1'b0;
        cmd_addr_out <= ~a;
        cmd_wdata_out <= ~d;
        @(posedge clock_in);
        for (n = 0; n < 4 && cmd_ack_in !== 1'b1; n++) begin
            @(posedge clock_in);
        end
        q = cmd_rdata_in;
        h = cmd_hit_in;
        dm = dummy_in;
    endtask
endmodule

// ==== dv/pod_error_report_registers_bench.sv ====
// self-checking bench for the error report register bank
module pod_error_report_registers_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0, rstn_in = 1'b0, valid, write, ack, hit, dummy, abort;
    logic fast = 1'b0, wait_en = 1'b0, breq_en = 1'b0, bt_set = 1'b0;
    logic start = 1'b0, stop = 1'b0, wait_ln = 1'b0, breq_ln = 1'b0;
    logic [31:0] addr, bt_addr = 32'h0, bt_out, lla, lha, llb, lhb;
    logic [15:0] wdata, rdata, live = 16'h0, cerr = 16'h0, rep_c, rep_f;
    logic [7:0]  fault = 8'h0;
    int err_total = 0, n_checks = 0, cycles = 0;
    perr_regs dut (.clock_in(clock_in), .rstn_in(rstn_in), .cmd_valid_in(valid),
        .cmd_write_in(write), .cmd_addr_in(addr), .cmd_wdata_in(wdata), .cmd_ack_out(ack),
        .cmd_hit_out(hit), .cmd_rdata_out(rdata), .dummy_read_req_out(dummy),
        .fast_mode_in(fast), .wait_enable_in(wait_en), .bus_request_enable_in(breq_en),
        .bus_test_addr_set_in(bt_set), .bus_test_addr_in(bt_addr), .access_start_in(start),
        .access_end_in(stop), .wait_line_in(wait_ln), .bus_request_line_in(breq_ln),
        .live_status_in(live), .control_drive_err_in(cerr), .fault_byte_in(fault),
        .access_abort_out(abort), .reported_ctrl_err_out(rep_c), .reported_force_err_out(rep_f),
        .bus_test_data_addr_out(bt_out), .learn_lo_a_out(lla), .learn_hi_a_out(lha),
        .learn_lo_b_out(llb), .learn_hi_b_out(lhb));
    perr_mainframe mf (.clock_in(clock_in), .cmd_ack_in(ack), .cmd_hit_in(hit),
        .cmd_rdata_in(rdata), .dummy_in(dummy), .cmd_valid_out(valid), .cmd_write_out(write),
        .cmd_addr_out(addr), .cmd_wdata_out(wdata));
    initial forever #5 clock_in = ~clock_in;
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // read one address; group reads must not ask a dummy read
    task automatic rd(input logic [31:0] a, input logic [15:0] exp, input logic h_exp);
        logic [15:0] q;
        logic h, dm;
        mf.xfer(1'b0, a, 16'h0000, q, h, dm);
        chk(q, exp, "read data");
        chk(h, h_exp, "hit");
        chk(dm, !(a >= perr_pkg::addr_group_first && a <= perr_pkg::addr_group_last), "dummy");
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic h, dm;
        mf.xfer(1'b1, a, d, q, h, dm);
        chk(h, 1'b1, "write hit");
    endtask
    // one target access with forcing lines held across it
    task automatic access(input int n);
        @(posedge clock_in) start <= 1'b1;
        @(posedge clock_in) start <= 1'b0;
        repeat (n) @(posedge clock_in);
        stop <= 1'b1;
        @(posedge clock_in) stop <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic t_defaults;
        rd(perr_pkg::addr_err_summary, 16'h00ff, 1'b1);
        rd(perr_pkg::addr_ctrl_mask, 16'hffff, 1'b1);
        rd(perr_pkg::addr_force_mask, 16'hffff, 1'b1);
        chk(bt_out, 32'h0800fffe, "bus test default");
        chk({lla, lha}, {32'h0d000000, 32'h0d00fffe}, "learn range a");
        chk({llb, lhb}, {32'h08000000, 32'h0800fffe}, "learn range b");
        $display("t_defaults done");
    endtask
    task automatic t_capture;
        wait_ln <= 1'b1;
        breq_ln <= 1'b1;
        live <= 16'h0314;
        fault <= 8'h18;
        cerr <= 16'h0400;
        access(10);
        rd(perr_pkg::addr_forcing_map, 16'h0005, 1'b1);
        rd(perr_pkg::addr_prev_status, 16'h0314, 1'b1);
        rd(perr_pkg::addr_err_summary, 16'h0018, 1'b1);
        chk(rep_f, 16'h0005, "force report");
        chk(rep_c, 16'h0400, "ctrl report");
        wait_en <= 1'b1;
        access(10);
        rd(perr_pkg::addr_forcing_map, 16'h0001, 1'b1);
        breq_en <= 1'b1;
        access(10);
        rd(perr_pkg::addr_forcing_map, 16'h0000, 1'b1);
        $display("t_capture done");
    endtask
    task automatic t_masks;
        wr(perr_pkg::addr_ctrl_mask, 16'hfbff);
        rd(perr_pkg::addr_ctrl_mask, 16'hfbff, 1'b1);
        chk(rep_c, 16'h0000, "ctrl masked");
        cerr <= 16'h0401;
        wait_en <= 1'b0;
        breq_en <= 1'b0;
        wr(perr_pkg::addr_force_mask, 16'hfffe);
        access(10);
        chk(rep_c, 16'h0001, "ctrl other line");
        chk(rep_f, 16'h0004, "force masked");
        rd(perr_pkg::addr_forcing_map, 16'h0005, 1'b1);
        wr(perr_pkg::addr_force_mask, 16'hffff);
        $display("t_masks done");
    endtask
    task automatic t_timeout;
        int n;
        fast <= 1'b1;
        wait_en <= 1'b1;
        breq_ln <= 1'b0;
        // bus request pin lags four edges through its synchroniser
        repeat (4) @(posedge clock_in);
        @(posedge clock_in) start <= 1'b1;
        @(posedge clock_in) start <= 1'b0;
        for (n = 0; n < 300 && abort !== 1'b1; n++) @(posedge clock_in);
        chk(n >= perr_pkg::wait_limit && n < 300, 1'b1, "abort timing");
        wait_ln <= 1'b0;
        repeat (4) @(posedge clock_in);
        chk(rep_f, 16'h0800, "timeout reported");
        wr(perr_pkg::addr_force_mask, 16'hf7ff);
        @(posedge clock_in); // report follows the mask one edge later
        chk(rep_f, 16'h0000, "timeout masked");
        $display("t_timeout done");
    endtask
    task automatic t_refused;
        wr(perr_pkg::addr_err_summary, 16'h1234);
        rd(perr_pkg::addr_err_summary, 16'h0018, 1'b1);
        rd(32'hf0000030, 16'h0000, 1'b0);
        wr(perr_pkg::addr_self_test, 16'ha5a5);
        rd(perr_pkg::addr_self_test, 16'ha5a5, 1'b1);
        @(posedge clock_in) bt_set <= 1'b1;
        bt_addr <= 32'h0d001234;
        @(posedge clock_in) bt_set <= 1'b0;
        @(posedge clock_in);
        chk(bt_out, 32'h0d001234, "bus test addr");
        $display("t_refused done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_defaults();
        t_capture();
        t_masks();
        t_timeout();
        t_refused();
        give_verdict();
    end
endmodule
